//--- dv/dct_ctrl_model.sv
// controller-side command driver facing the timing block
`timescale 1ns/10ps
`default_nettype none
module dct_ctrl_model
    import dct_pkg::*;
(
    input  wire logic         ref_clk_i,
    output logic              cmd_valid_o,
    output dct_cmd_e          cmd_o,
    output logic [BANK_W-1:0] bank_o,
    output logic              auto_pre_o
);
    initial begin
        cmd_valid_o = 1'b0;
        cmd_o       = DCT_NOP;
        bank_o      = '0;
        auto_pre_o  = 1'b0;
    end
    // 40 MHz is not slower than 40ns, so no precharge all after refresh
    // cke is never dropped, so no refresh-to-power-down wait arises
    task automatic send(input dct_cmd_e c, input int b,
                        input logic ap);
        int n;
        @(posedge ref_clk_i);
        #1;
        cmd_valid_o = (c != DCT_NOP);
        cmd_o       = c;
        bank_o      = BANK_W'(b);
        auto_pre_o  = ap;
        // gaps counted in real edges, rounded up, never shorter
        n = (c == DCT_REF) ? 1 : 0;
        if (c == DCT_PRE) n = int'(N_RP) - 1;
        repeat (n) begin
            @(posedge ref_clk_i);
            #1;
            cmd_valid_o = 1'b0;
        end
    endtask
endmodule
`default_nettype wire

//--- dv/dct_timing_tb_top.sv
// self-checking bench for the command timing block
`timescale 1ns/10ps
`default_nettype none
module dct_timing_tb_top
    import dct_pkg::*;
;
    logic                 ref_clk_i = 1'b0;
    logic                 rst_i     = 1'b1;
    logic                 cmd_valid;
    dct_cmd_e             cmd;
    logic [BANK_W-1:0]    bank;
    logic                 auto_pre;
    logic                 bc4       = 1'b0;
    logic                 dll_off   = 1'b0;
    logic [LAT_W-1:0]     cl        = 5'h05;
    logic [LAT_W-1:0]     al        = 5'h00;
    logic [LAT_W-1:0]     cwl       = 5'h05;
    logic [NUM_BANKS-1:0] int_pre, act_ok;
    logic                 wr_rec, rd_ref, sp_err, norm, rs, dl;
    int                   cyc       = 0;
    int                   error_cnt = 0;
    int                   n_tests   = 0;
    int                   act_at[NUM_BANKS];
    bit                   exp_wr[4096], exp_rd[4096];
    bit [NUM_BANKS-1:0]   exp_pre[4096];

    always #12.5 ref_clk_i = ~ref_clk_i;

    dct_ctrl_model dct_ctrl_model_inst (
        .ref_clk_i(ref_clk_i), .cmd_valid_o(cmd_valid), .cmd_o(cmd),
        .bank_o(bank), .auto_pre_o(auto_pre)
    );
    dct_timing dct_timing_inst (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid),
        .cmd_i(cmd), .bank_i(bank), .auto_pre_i(auto_pre),
        .bc4_fixed_i(bc4), .dll_off_i(dll_off), .cl_i(cl), .al_i(al),
        .cwl_i(cwl), .int_pre_o(int_pre), .act_ok_o(act_ok),
        .wr_rec_start_o(wr_rec), .rd_ref_o(rd_ref),
        .spacing_err_o(sp_err), .norm_timing_o(norm)
    );

    task automatic finish_test();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input bit ok, input string m);
        n_tests++;
        if (!ok) begin
            error_cnt++;
            $display("Error %0t: %s", $time, m);
        end
    endtask

    // model: pulse cycles worked out when each command goes out
    task automatic cmd_go(input dct_cmd_e c, input int b, input bit ap);
        int t;
        dct_ctrl_model_inst.send(c, b, ap);
        t = cyc;
        if (c == DCT_ACT) act_at[b] = t;
        if (c == DCT_WR) exp_wr[t + cwl + al + (bc4 ? 2 : 4)] = 1'b1;
        if (c == DCT_RD && dll_off) exp_rd[t + cl + al - 1] = 1'b1;
        if (ap && (c == DCT_RD || c == DCT_WR)) begin
            // fires one edge after the later of row age met and the request
            t = (act_at[b] + int'(N_RAS) > t + 1) ? act_at[b] + int'(N_RAS)
                                                   : t + 1;
            exp_pre[t + 1][b] = 1'b1;
        end
    endtask

    // checks land 2ns after the edge, after stimulus has settled
    always @(posedge ref_clk_i) begin
        rs = rst_i;
        dl = dll_off;
        cyc++;
        #2;
        if (cyc > 4000) begin
            error_cnt++;
            finish_test();
        end else if (rs) begin
            chk(int_pre === '0 && act_ok === '1 && norm === 1'b0, "reset");
            chk(wr_rec === 1'b0 && rd_ref === 1'b0, "reset pulses");
        end else begin
            chk(wr_rec === exp_wr[cyc], "write recovery start");
            chk(rd_ref === exp_rd[cyc], "read strobe reference");
            chk(int_pre === exp_pre[cyc], "internal precharge");
            chk(sp_err === 1'b0, "legal spacing flagged");
            chk(norm === !dl, "normal timing flag");
        end
    end

    initial begin
        void'($urandom(69907));
        foreach (act_at[i]) act_at[i] = -100;
        repeat (8) @(posedge ref_clk_i);
        #1;
        rst_i = 1'b0;
        for (int r = 0; r < 40; r++) begin
            int b;
            b = $urandom_range(0, 7);
            cmd_go(DCT_PRE, b, 1'b0);
            cmd_go(DCT_ACT, b, 1'b0);
            cmd_go(DCT_WR, b, 1'($urandom_range(0, 1)));
            cmd_go(DCT_RD, b ^ 1, 1'b1);
            cmd_go(DCT_WR, (b + 2) % 8, 1'b0);
            cmd_go(DCT_RD, b, 1'b0);
            // a refresh pair every pass: none postponed, debt stays zero
            cmd_go(DCT_REF, 0, 1'b0);
            cmd_go(DCT_REF, 0, 1'b0);
            cmd_go(DCT_NOP, 0, 1'b0);
            // latencies change only once every pulse has drained
            repeat (24) @(posedge ref_clk_i);
            #1;
            cl      = LAT_W'($urandom_range(5, 11));
            al      = (r % 3 == 0) ? 5'h00 : cl - LAT_W'(r % 3);
            cwl     = LAT_W'($urandom_range(5, 8));
            bc4     = 1'($urandom_range(0, 1));
            dll_off = 1'($urandom_range(0, 1));
            // first passes pinned so the minimum-latency checks must fire
            if (r < 2) begin
                cl      = 5'h05;
                al      = 5'h00;
                cwl     = 5'h05;
                bc4     = 1'(r);
                dll_off = 1'b1;
            end
            // relock wait after a latency change, before the next read
            repeat (16) @(posedge ref_clk_i);
        end
        finish_test();
    end
endmodule
`default_nettype wire

//--- verilog/dct_pkg.sv
// constants and command codes for the ddr3 command timing block
package dct_pkg;
    localparam int          CLK_PERIOD_PS = 25000;
    localparam int          NUM_BANKS     = 8;
    localparam int          BANK_W        = 3;
    localparam int          CNT_W         = 4;
    localparam int          LAT_W         = 5;
    localparam int          SR_W          = 32;
    // precharge period, picoseconds
    localparam int          T_RP_PS       = 15000;
    // activate-to-precharge minimum, plain default, picoseconds
    localparam int          T_RAS_PS      = 35000;
    // least times round up to whole cycles, never below one
    localparam int          N_RP_I   = (T_RP_PS + CLK_PERIOD_PS - 1)
                                       / CLK_PERIOD_PS;
    localparam int          N_RAS_I  = (T_RAS_PS + CLK_PERIOD_PS - 1)
                                       / CLK_PERIOD_PS;
    localparam logic [CNT_W-1:0] N_RP    = CNT_W'((N_RP_I < 1) ? 1 : N_RP_I);
    localparam logic [CNT_W-1:0] N_RAS   = CNT_W'((N_RAS_I < 1) ? 1 : N_RAS_I);
    localparam logic [CNT_W-1:0] CNT_MAX = 4'hF;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    // write recovery start offsets after write latency
    localparam logic [LAT_W-1:0] WR_OFS_BL8 = 5'h04;
    localparam logic [LAT_W-1:0] WR_OFS_BC4 = 5'h02;
    // strobe reference is one cycle before cl + al
    localparam logic [LAT_W-1:0] RD_OFS     = 5'h01;
    // shift-register placement: the load into the register and the output flop add one cycle each
    localparam logic [LAT_W-1:0] SR_OFS     = 5'h02;

    typedef enum logic [2:0] {
        DCT_NOP  = 3'h0,
        DCT_ACT  = 3'h1,
        DCT_RD   = 3'h2,
        DCT_WR   = 3'h3,
        DCT_PRE  = 3'h4,
        DCT_PREA = 3'h5,
        DCT_REF  = 3'h6
    } dct_cmd_e;
endpackage

//--- verilog/dct_timing.sv
// device-side command timing: auto precharge hold-off, recovery, strobe ref
`timescale 1ns/10ps
`default_nettype none
module dct_timing
    import dct_pkg::*;
(
    input  wire logic              ref_clk_i,
    input  wire logic              rst_i,
    input  wire logic              cmd_valid_i,
    input  wire dct_cmd_e          cmd_i,
    input  wire logic [BANK_W-1:0] bank_i,
    input  wire logic              auto_pre_i,
    input  wire logic              bc4_fixed_i,
    input  wire logic              dll_off_i,
    input  wire logic [LAT_W-1:0]  cl_i,
    input  wire logic [LAT_W-1:0]  al_i,
    input  wire logic [LAT_W-1:0]  cwl_i,
    output logic [NUM_BANKS-1:0]   int_pre_o,
    output logic [NUM_BANKS-1:0]   act_ok_o,
    output logic                   wr_rec_start_o,
    output logic                   rd_ref_o,
    output logic                   spacing_err_o,
    output logic                   norm_timing_o
);

    logic [NUM_BANKS-1:0] int_pre_q;
    logic [NUM_BANKS-1:0] act_ok_q;
    logic [NUM_BANKS-1:0] ras_met;
    logic                 is_act;
    logic                 is_rd;
    logic                 is_wr;
    logic                 is_pre;
    logic                 is_prea;

    assign is_act  = cmd_valid_i && (cmd_i == DCT_ACT);
    assign is_rd   = cmd_valid_i && (cmd_i == DCT_RD);
    assign is_wr   = cmd_valid_i && (cmd_i == DCT_WR);
    assign is_pre  = cmd_valid_i && (cmd_i == DCT_PRE);
    assign is_prea = cmd_valid_i && (cmd_i == DCT_PREA);

    // per-bank activate age, precharge age and pending auto precharge
    for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
        logic             hit;
        logic [CNT_W-1:0] ras_q;
        logic [CNT_W-1:0] ras_d;
        logic [CNT_W-1:0] rp_q;
        logic [CNT_W-1:0] rp_d;
        logic             pend_q;
        logic             pend_d;
        logic             ipre_d;
        logic             ok_d;

        assign hit        = (bank_i == BANK_W'(b));
        assign ras_met[b] = (ras_q >= N_RAS);

        always_comb begin
            ras_d  = (ras_q == CNT_MAX) ? ras_q : ras_q + CNT_ONE;
            rp_d   = (rp_q == CNT_MAX) ? rp_q : rp_q + CNT_ONE;
            pend_d = pend_q;
            // hold-off until the row has been open long enough
            ipre_d = pend_q && ras_met[b];
            if (ipre_d) begin
                pend_d = 1'b0;
            end
            // a new auto precharge in the firing cycle is not lost
            if (hit && (is_rd || is_wr) && auto_pre_i) begin
                pend_d = 1'b1;
            end
            if (hit && is_act) begin
                ras_d = CNT_ONE;
            end
            if ((hit && is_pre) || is_prea || ipre_d) begin
                rp_d = CNT_ONE;
            end
            // age counts edges, so jitter-short cycles still qualify
            ok_d = (rp_d >= N_RP);
        end

        always_ff @(posedge ref_clk_i) begin
            if (rst_i) begin
                ras_q        <= CNT_MAX;
                rp_q         <= CNT_MAX;
                pend_q       <= 1'b0;
                int_pre_q[b] <= 1'b0;
                act_ok_q[b]  <= 1'b1;
            end else begin
                ras_q        <= ras_d;
                rp_q         <= rp_d;
                pend_q       <= pend_d;
                int_pre_q[b] <= ipre_d;
                act_ok_q[b]  <= ok_d;
            end
        end

        a_ap_holdoff: assert property (@(posedge ref_clk_i) disable iff (rst_i)
            int_pre_q[b] |-> $past(ras_met[b]))
            else $error("internal precharge before row minimum");

        a_ap_fires: assert property (@(posedge ref_clk_i) disable iff (rst_i)
            (hit && is_act) ##1 (hit && is_wr && auto_pre_i)
            |-> ##[1:16] int_pre_q[b])
            else $error("auto precharge never issued");

        a_rp_spacing: assert property (@(posedge ref_clk_i) disable iff (rst_i)
            (hit && is_pre) |=> act_ok_q[b])
            else $error("rounded precharge spacing refused");
    end

    // latency pipelines; each write, and each read with the dll off, plants one bit at its offset
    logic [SR_W-1:0]  wr_sr_q;
    logic [SR_W-1:0]  wr_sr_d;
    logic [SR_W-1:0]  rd_sr_q;
    logic [SR_W-1:0]  rd_sr_d;
    logic [LAT_W-1:0] wr_dly;
    logic [LAT_W-1:0] rd_dly;
    logic             err_d;
    logic             wr_rec_q;
    logic             rd_ref_q;
    logic             err_q;
    logic             norm_q;

    always_comb begin
        // fixed bc4 recovers two cycles earlier; otf bc4 keeps bl8 timing
        wr_dly = cwl_i + al_i
               + (bc4_fixed_i ? WR_OFS_BC4 : WR_OFS_BL8);
        // only defined with the dll off; normal mode uses the dll path
        rd_dly = cl_i + al_i - RD_OFS;
        wr_sr_d = wr_sr_q >> 1;
        rd_sr_d = rd_sr_q >> 1;
        if (is_wr) begin
            wr_sr_d[wr_dly - SR_OFS] = 1'b1;
        end
        if (is_rd && dll_off_i) begin
            rd_sr_d[rd_dly - SR_OFS] = 1'b1;
        end
        err_d = 1'b0;
        for (int i = 0; i < NUM_BANKS; i++) begin
            if (is_act && (bank_i == BANK_W'(i)) && !act_ok_q[i]) begin
                err_d = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            wr_sr_q  <= '0;
            rd_sr_q  <= '0;
            wr_rec_q <= 1'b0;
            rd_ref_q <= 1'b0;
            err_q    <= 1'b0;
            norm_q   <= 1'b0;
        end else begin
            wr_sr_q  <= wr_sr_d;
            rd_sr_q  <= rd_sr_d;
            wr_rec_q <= wr_sr_q[0];
            rd_ref_q <= rd_sr_q[0];
            err_q    <= err_d;
            norm_q   <= !dll_off_i;
        end
    end

    assign int_pre_o      = int_pre_q;
    assign act_ok_o       = act_ok_q;
    assign wr_rec_start_o = wr_rec_q;
    assign rd_ref_o       = rd_ref_q;
    assign spacing_err_o  = err_q;
    assign norm_timing_o  = norm_q;

    sequence s_wr_min;
        is_wr && cwl_i == 5'h05 && al_i == 5'h00;
    endsequence

    sequence s_rd_min;
        is_rd && dll_off_i && cl_i == 5'h05 && al_i == 5'h00;
    endsequence

    a_wr_rec_bl8: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (s_wr_min and !bc4_fixed_i) |-> ##9 wr_rec_q)
        else $error("bl8 write recovery start misplaced");

    a_wr_rec_bc4: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (s_wr_min and bc4_fixed_i) |-> ##7 wr_rec_q)
        else $error("bc4 write recovery start misplaced");

    a_rd_ref_time: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        s_rd_min |-> ##4 rd_ref_q)
        else $error("dll-off strobe reference misplaced");

    a_norm_flag: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        dll_off_i [*2] |-> !norm_timing_o)
        else $error("normal timing claimed with dll off");

endmodule
`default_nettype wire
